// *** hp_pkg.sv ***
// constants for the host port and reset control block
package hp_pkg;
	localparam int unsigned CLK_MHZ = 40;
	// least wait after hardware reset, in master clock cycles
	localparam int unsigned RESET_WAIT_CYCLES = 75;
	localparam logic [15:0] OFF_MAIN_CONTROL = 16'h0000;
	localparam logic [15:0] OFF_MAIN_STATUS = 16'h0002;
	localparam logic [15:0] OFF_WINDOW = 16'h0030;
	localparam logic [15:0] MAIN_CONTROL_RST = 16'h0000;
	localparam logic [15:0] WINDOW_RST = 16'h0000;
	localparam logic [15:0] HOST_GROUP_LIMIT = 16'h0100;
	localparam int unsigned RELEASE_BIT = 15;
	localparam int unsigned CLKEN_BIT = 14;
	localparam int unsigned CLKEN2_BIT = 10;
	localparam int unsigned PAGE_W = 5;
	localparam int unsigned WAIT_W = 7;
	localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(RESET_WAIT_CYCLES - 1);
	// status bits
	localparam int unsigned STAT_WAIT_DONE = 0;
	localparam int unsigned STAT_CLK_ON = 1;
	localparam int unsigned STAT_RUN = 2;
	// scheduler slot counts per backplane rate
	localparam logic [1:0] RATE_2M = 2'h0;
	localparam logic [1:0] RATE_4M = 2'h1;
	localparam logic [1:0] RATE_8M = 2'h2;
	localparam logic [10:0] SLOTS_2M = 11'h100;
	localparam logic [10:0] SLOTS_4M = 11'h200;
	localparam logic [10:0] SLOTS_8M = 11'h400;
	localparam logic [10:0] MAX_VC = 11'h400;
	typedef enum logic [3:0] {
		BOOT_HELD = 4'h1,
		BOOT_WAITED = 4'h2,
		BOOT_CLOCKS = 4'h4,
		BOOT_RUNNING = 4'h8
	} boot_t;
endpackage : hp_pkg

// *** wait_counter.sv ***
// saturating cycle counter for the post reset wait
`timescale 1ns/1ps
module wait_counter #(
	parameter int unsigned W = 7,
	parameter logic [W-1:0] LAST = '1
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// status
	output logic done
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic done_nxt;
	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = done;
		if (cnt_r == LAST) begin
			done_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + W'(1);
		end
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
			done <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done <= done_nxt;
		end
	end
endmodule : wait_counter

// *** host_port_reset_control.sv ***
// host word port, register decode, page window and soft reset sequencing
`timescale 1ns/1ps
module host_port_reset_control (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// host access
	input wire logic access_strobe,
	input wire logic write_en,
	input wire logic memory_space_select,
	input wire logic [15:1] host_addr,
	input wire logic [15:0] host_wdata,
	// backplane rate from the tdm side
	input wire logic [1:0] backplane_rate,
	// answers to host
	output logic [15:0] host_rdata,
	output logic host_ack,
	// internal register space
	output logic reg_strobe,
	output logic reg_write,
	output logic [15:1] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// external memory window
	output logic mem_strobe,
	output logic mem_write,
	output logic [20:1] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ready,
	// device control
	output logic soft_reset_release,
	output logic clocks_enabled,
	output logic [10:0] slot_limit,
	output logic [10:0] vc_limit
);
	// ----------------------------------------
	// start-up wait
	// ----------------------------------------
	logic wait_done;
	wait_counter #(
		.W(hp_pkg::WAIT_W),
		.LAST(hp_pkg::WAIT_LAST)
	) u_wait (
		.clock(clock),
		.nrst(nrst),
		.done(wait_done)
	);

	// ----------------------------------------
	// registers and access engine
	// ----------------------------------------
	logic [15:0] main_control_r, main_control_nxt;
	logic [hp_pkg::PAGE_W-1:0] page_r, page_nxt;
	logic [15:0] rdata_nxt;
	logic ack_nxt;
	logic mem_busy_r, mem_busy_nxt;
	logic mstb_nxt, mwr_nxt;
	logic [20:1] maddr_nxt;
	logic [15:0] mwdata_nxt;
	logic rstb_nxt, rwr_nxt;
	logic [15:1] raddr_nxt;
	logic [15:0] rwdata_nxt;
	logic [10:0] slot_nxt;
	logic release_nxt, clk_nxt;
	hp_pkg::boot_t boot_r, boot_nxt;
	logic [15:0] byte_addr;
	logic [15:0] status_word;
	logic released;

	assign byte_addr = {host_addr, 1'b0};
	assign released = main_control_r[hp_pkg::RELEASE_BIT];
	always_comb begin
		status_word = '0;
		status_word[hp_pkg::STAT_WAIT_DONE] = wait_done;
		status_word[hp_pkg::STAT_CLK_ON] = boot_r inside {hp_pkg::BOOT_CLOCKS, hp_pkg::BOOT_RUNNING};
		status_word[hp_pkg::STAT_RUN] = boot_r == hp_pkg::BOOT_RUNNING;
	end

	always_comb begin
		main_control_nxt = main_control_r;
		page_nxt = page_r;
		rdata_nxt = host_rdata;
		ack_nxt = 1'b0;
		mem_busy_nxt = mem_busy_r;
		mstb_nxt = 1'b0;
		mwr_nxt = mem_write;
		maddr_nxt = mem_addr;
		mwdata_nxt = mem_wdata;
		rstb_nxt = 1'b0;
		rwr_nxt = reg_write;
		raddr_nxt = reg_addr;
		rwdata_nxt = reg_wdata;
		if (mem_busy_r) begin
			// stall the host until memory answers
			if (mem_ready) begin
				mem_busy_nxt = 1'b0;
				ack_nxt = 1'b1;
				rdata_nxt = mem_write ? 16'h0000 : mem_rdata;
			end
		end else if (access_strobe) begin
			if (memory_space_select) begin
				mstb_nxt = 1'b1;
				mwr_nxt = write_en;
				maddr_nxt = {page_r, host_addr};
				mwdata_nxt = host_wdata;
				mem_busy_nxt = 1'b1;
			end else begin
				ack_nxt = 1'b1;
				rdata_nxt = 16'h0000;
				if (byte_addr == hp_pkg::OFF_MAIN_CONTROL) begin
					if (write_en) begin
						main_control_nxt = host_wdata;
					end
					rdata_nxt = main_control_r;
				end else if (byte_addr == hp_pkg::OFF_MAIN_STATUS) begin
					rdata_nxt = status_word;
				end else if (byte_addr == hp_pkg::OFF_WINDOW) begin
					if (write_en) begin
						page_nxt = host_wdata[hp_pkg::PAGE_W-1:0];
					end
					rdata_nxt = {11'h000, page_r};
				end else if (byte_addr >= hp_pkg::HOST_GROUP_LIMIT && released && soft_reset_release) begin
					// outside the host group: passed on only after release
					ack_nxt = 1'b0;
					rstb_nxt = 1'b1;
					rwr_nxt = write_en;
					raddr_nxt = host_addr;
					rwdata_nxt = host_wdata;
				end
			end
		end
		if (reg_strobe) begin
			// internal registers answer one cycle after the strobe
			ack_nxt = 1'b1;
			rdata_nxt = reg_write ? 16'h0000 : reg_rdata;
		end
	end

	// ----------------------------------------
	// soft reset sequencing
	// ----------------------------------------
	always_comb begin
		boot_nxt = boot_r;
		unique case (boot_r)
			hp_pkg::BOOT_HELD: if (wait_done) boot_nxt = hp_pkg::BOOT_WAITED;
			hp_pkg::BOOT_WAITED: if (main_control_r[hp_pkg::CLKEN_BIT]) boot_nxt = hp_pkg::BOOT_CLOCKS;
			hp_pkg::BOOT_CLOCKS: if (released) boot_nxt = hp_pkg::BOOT_RUNNING;
			hp_pkg::BOOT_RUNNING: if (!released) boot_nxt = hp_pkg::BOOT_WAITED;
			default: boot_nxt = hp_pkg::BOOT_HELD;
		endcase
		// zero written to control pulls the device back into reset
		if (boot_r != hp_pkg::BOOT_HELD && main_control_r == hp_pkg::MAIN_CONTROL_RST) begin
			boot_nxt = hp_pkg::BOOT_WAITED;
		end
		release_nxt = released && boot_r inside {hp_pkg::BOOT_CLOCKS, hp_pkg::BOOT_RUNNING};
		clk_nxt = main_control_r[hp_pkg::CLKEN_BIT] && main_control_r[hp_pkg::CLKEN2_BIT];
		unique case (backplane_rate)
			hp_pkg::RATE_2M: slot_nxt = hp_pkg::SLOTS_2M;
			hp_pkg::RATE_4M: slot_nxt = hp_pkg::SLOTS_4M;
			default: slot_nxt = hp_pkg::SLOTS_8M;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			main_control_r <= hp_pkg::MAIN_CONTROL_RST;
			page_r <= hp_pkg::WINDOW_RST[hp_pkg::PAGE_W-1:0];
			host_rdata <= '0;
			host_ack <= 1'b0;
			mem_busy_r <= 1'b0;
			mem_strobe <= 1'b0;
			mem_write <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
			reg_strobe <= 1'b0;
			reg_write <= 1'b0;
			reg_addr <= '0;
			reg_wdata <= '0;
			boot_r <= hp_pkg::BOOT_HELD;
			soft_reset_release <= 1'b0;
			clocks_enabled <= 1'b0;
			slot_limit <= hp_pkg::SLOTS_2M;
			vc_limit <= hp_pkg::MAX_VC;
		end else begin
			main_control_r <= main_control_nxt;
			page_r <= page_nxt;
			host_rdata <= rdata_nxt;
			host_ack <= ack_nxt;
			mem_busy_r <= mem_busy_nxt;
			mem_strobe <= mstb_nxt;
			mem_write <= mwr_nxt;
			mem_addr <= maddr_nxt;
			mem_wdata <= mwdata_nxt;
			reg_strobe <= rstb_nxt;
			reg_write <= rwr_nxt;
			reg_addr <= raddr_nxt;
			reg_wdata <= rwdata_nxt;
			boot_r <= boot_nxt;
			soft_reset_release <= release_nxt;
			clocks_enabled <= clk_nxt;
			slot_limit <= slot_nxt;
			vc_limit <= hp_pkg::MAX_VC;
		end
	end
endmodule : host_port_reset_control

// *** hp_checker.sv ***
// assertions on the ports of the host port and reset control block
`timescale 1ns/1ps
module hp_checker (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// host side
	input wire logic access_strobe,
	input wire logic memory_space_select,
	input wire logic [15:1] host_addr,
	input wire logic [1:0] backplane_rate,
	input wire logic host_ack,
	// device side
	input wire logic reg_strobe,
	input wire logic mem_strobe,
	input wire logic [20:1] mem_addr,
	input wire logic soft_reset_release,
	input wire logic clocks_enabled,
	input wire logic [10:0] slot_limit
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	chk_ack_single: assert property (host_ack |=> !host_ack)
		else $error("host ack longer than one cycle");
	chk_ack_bound: assert property (access_strobe && !memory_space_select |-> ##[1:2] host_ack)
		else $error("register access not answered in time");
	chk_mem_route: assert property (mem_strobe |-> $past(access_strobe && memory_space_select))
		else $error("memory strobe without memory access");
	chk_mem_word: assert property (mem_strobe |-> mem_addr[15:1] == $past(host_addr))
		else $error("memory word address differs from host");
	chk_held_inert: assert property (!soft_reset_release |=> !reg_strobe)
		else $error("register strobe while held in reset");
	chk_release_clk: assert property ($rose(soft_reset_release) |-> clocks_enabled)
		else $error("release without clocks enabled");
	chk_release_write: assert property ($rose(soft_reset_release) |-> $past(host_ack))
		else $error("release not after a control write");
	chk_slot_mid: assert property ($past(backplane_rate) == 2'h1 |-> slot_limit == 11'h200)
		else $error("slot count wrong at middle rate");
	chk_slot_top: assert property ($past(backplane_rate[1]) |-> slot_limit == 11'h400)
		else $error("slot count wrong at top rate");
endmodule : hp_checker

bind host_port_reset_control hp_checker chk_i (
	.clock(clock),
	.nrst(nrst),
	.access_strobe(access_strobe),
	.memory_space_select(memory_space_select),
	.host_addr(host_addr),
	.backplane_rate(backplane_rate),
	.host_ack(host_ack),
	.reg_strobe(reg_strobe),
	.mem_strobe(mem_strobe),
	.mem_addr(mem_addr),
	.soft_reset_release(soft_reset_release),
	.clocks_enabled(clocks_enabled),
	.slot_limit(slot_limit)
);

// *** hp_mem_model.sv ***
// behavioural external memory and internal register space
`timescale 1ns/1ps
module hp_mem_model (
	// clock
	input wire logic clock,
	// memory window
	input wire logic mem_strobe,
	input wire logic mem_write,
	input wire logic [20:1] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_ready,
	output logic [20:1] mem_last_addr,
	// internal register space
	input wire logic [15:1] reg_addr,
	output logic [15:0] reg_rdata
);
	logic [15:0] mem [16];
	int wait_n = 0;
	logic slow = 1'b0;
	initial mem_rdata = 16'h0000;
	initial mem_ready = 1'b0;
	assign reg_rdata = {reg_addr, 1'b0} ^ 16'h5a5a;
	// answers alternate fast and slow; data toggles outside an answer
	always @(posedge clock) begin
		mem_ready <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_strobe) begin
			mem_last_addr <= mem_addr;
			wait_n <= slow ? 4 : 1;
			slow <= ~slow;
			if (mem_write) mem[mem_addr[4:1]] <= mem_wdata;
		end else if (wait_n == 1) begin
			mem_ready <= 1'b1;
			mem_rdata <= mem[mem_last_addr[4:1]];
			wait_n <= 0;
		end else if (wait_n > 1) wait_n <= wait_n - 1;
	end
endmodule : hp_mem_model

// *** tb_top.sv ***
// self-checking bench for the host port and reset control block
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic access_strobe = 1'b0;
	logic write_en = 1'b0;
	logic memory_space_select = 1'b0;
	logic [15:1] host_addr = 15'h0000;
	logic [15:0] host_wdata = 16'h0000;
	logic [1:0] backplane_rate = 2'h0;
	logic [15:0] host_rdata, reg_rdata, reg_wdata, mem_rdata, mem_wdata, rd;
	logic host_ack, reg_strobe, reg_write, mem_strobe, mem_write, mem_ready;
	logic soft_reset_release, clocks_enabled;
	logic [15:1] reg_addr;
	logic [20:1] mem_addr, mem_last_addr;
	logic [10:0] slot_limit, vc_limit;
	int n_fail = 0;
	int samples_checked = 0;
	initial forever #12.5 clock = ~clock;
	host_port_reset_control uut (.clock, .nrst, .access_strobe, .write_en,
		.memory_space_select, .host_addr, .host_wdata, .backplane_rate, .host_rdata,
		.host_ack, .reg_strobe, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
		.mem_strobe, .mem_write, .mem_addr, .mem_wdata, .mem_rdata, .mem_ready,
		.soft_reset_release, .clocks_enabled, .slot_limit, .vc_limit);
	hp_mem_model far (.clock, .mem_strobe, .mem_write, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ready, .mem_last_addr, .reg_addr, .reg_rdata);
	// ----
	// shared tasks
	// ----
	task report_and_stop;
		if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one word access; the strobe is a single cycle pulse
	task acc(input logic we, input logic sel, input logic [15:0] a, input logic [15:0] d);
		int i;
		@(posedge clock);
		access_strobe <= 1'b1;
		write_en <= we;
		memory_space_select <= sel;
		host_addr <= a[15:1];
		host_wdata <= d;
		@(posedge clock);
		access_strobe <= 1'b0;
		i = 0;
		do begin
			@(negedge clock);
			i++;
		end while (host_ack !== 1'b1 && i < 40);
		if (host_ack !== 1'b1) begin
			n_fail++;
			report_and_stop();
		end
		rd = host_rdata;
	endtask : acc
	// ----
	// scenarios
	// ----
	task t_held;
		acc(1'b0, 1'b0, 16'h0000, 16'h0000);
		chk(rd, 16'h0000);
		acc(1'b0, 1'b0, 16'h0002, 16'h0000);
		chk(rd & 16'h0001, 16'h0000);
		acc(1'b1, 1'b0, 16'h2004, 16'h1234);
		chk(reg_wdata, 16'h0000);
		acc(1'b0, 1'b0, 16'h2004, 16'h0000);
		chk(rd, 16'h0000);
		repeat (80) @(posedge clock);
		acc(1'b0, 1'b0, 16'h0002, 16'h0000);
		chk(rd & 16'h0001, 16'h0001);
	endtask : t_held
	task t_boot;
		acc(1'b1, 1'b0, 16'h0000, 16'h4400);
		@(negedge clock);
		chk({15'h0000, clocks_enabled}, 16'h0001);
		acc(1'b1, 1'b0, 16'h0000, 16'hc400);
		@(negedge clock);
		chk({15'h0000, soft_reset_release}, 16'h0001);
		acc(1'b1, 1'b0, 16'h0000, 16'hc400);
		acc(1'b0, 1'b0, 16'h0000, 16'h0000);
		chk(rd, 16'hc400);
		acc(1'b0, 1'b0, 16'h0002, 16'h0000);
		chk(rd & 16'h0007, 16'h0007);
	endtask : t_boot
	task t_regs;
		acc(1'b1, 1'b0, 16'h2004, 16'h1234);
		chk(reg_wdata, 16'h1234);
		chk({reg_addr, reg_write}, 16'h2005);
		acc(1'b0, 1'b0, 16'h2004, 16'h0000);
		chk(rd, 16'h7a5e);
	endtask : t_regs
	task t_window;
		acc(1'b1, 1'b0, 16'h0030, 16'h0013);
		acc(1'b0, 1'b0, 16'h0030, 16'h0000);
		chk(rd, 16'h0013);
		acc(1'b1, 1'b1, 16'h0008, 16'hbeef);
		chk(mem_last_addr[16:1], 16'h8004);
		chk({11'h000, mem_last_addr[20:16]}, 16'h0013);
		acc(1'b0, 1'b1, 16'h0008, 16'h0000);
		chk(rd, 16'hbeef);
		acc(1'b1, 1'b0, 16'h2010, 16'h0001);
		chk(reg_wdata, 16'h0001);
	endtask : t_window
	task t_hwreset;
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		chk({15'h0000, soft_reset_release}, 16'h0000);
		acc(1'b0, 1'b0, 16'h0030, 16'h0000);
		chk(rd, 16'h0000);
	endtask : t_hwreset
	task t_rates;
		for (int r = 0; r < 4; r++) begin
			@(posedge clock);
			backplane_rate <= 2'(r);
			repeat (2) @(negedge clock);
			chk({5'h0, slot_limit}, r == 0 ? 16'h0100 : r == 1 ? 16'h0200 : 16'h0400);
		end
		chk({5'h0, vc_limit}, 16'h0400);
	endtask : t_rates
	task t_soft;
		acc(1'b1, 1'b0, 16'h0000, 16'h0000);
		@(negedge clock);
		chk({15'h0000, soft_reset_release}, 16'h0000);
		acc(1'b0, 1'b0, 16'h2004, 16'h0000);
		chk(rd, 16'h0000);
	endtask : t_soft
	initial begin
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		t_held();
		t_boot();
		t_regs();
		t_window();
		t_hwreset();
		t_rates();
		t_soft();
		report_and_stop();
	end
endmodule : tb_top
